/* File: pkg/mvc_pkg.sv */
package mvc_pkg;
  // Table geometry
  localparam int NUM_ENTRIES = 8;
  localparam int IDX_W       = 3;
  localparam int MAC_W       = 48;
  localparam int VID_W       = 12;
  localparam int PRI_W       = 3;
  // Legal VLAN identifier range
  localparam logic [VID_W-1:0] VID_MIN = 12'h001;
  localparam logic [VID_W-1:0] VID_MAX = 12'hFFE;
  // Reset values
  localparam logic [MAC_W-1:0] MAC_RST = 48'h0000_0000_0000;
  localparam logic [VID_W-1:0] VID_RST = 12'h000;
  localparam logic [PRI_W-1:0] PRI_RST = 3'h0;
  localparam logic [IDX_W-1:0] IDX_RST = 3'h0;
  // Verdict encoding of a classified frame
  typedef enum logic [1:0] {
    MVC_NO_MATCH = 2'b00,
    MVC_FORWARD  = 2'b01,
    MVC_DROP     = 2'b11
  } mvc_verdict_t;
  // Masked compare of one entry against a source address
  function automatic logic mvc_hit(input logic [MAC_W-1:0] sa,
                                   input logic [MAC_W-1:0] key,
                                   input logic [MAC_W-1:0] msk);
    mvc_hit = ((sa ^ key) & msk) == MAC_RST;
  endfunction
endpackage

/* File: hw/mvc_entry.sv */
`timescale 1ns/1ps
// One mapping entry: storage plus masked compare
module mvc_entry
  import mvc_pkg::*;
(
  input  wire logic               sys_clk,
  input  wire logic               rst_b,
  input  wire logic               wr_en,
  input  wire logic               wr_active,
  input  wire logic [MAC_W-1:0]   wr_mac,
  input  wire logic [MAC_W-1:0]   wr_mask,
  input  wire logic [VID_W-1:0]   wr_vid,
  input  wire logic [PRI_W-1:0]   wr_pri,
  input  wire logic [MAC_W-1:0]   src_mac,
  output logic                    hit,
  output logic [VID_W-1:0]        vid,
  output logic [PRI_W-1:0]        pri
);
  logic             active;   // Entry takes part in lookup
  logic [MAC_W-1:0] key;      // Stored address
  logic [MAC_W-1:0] msk;      // Per-bit match mask

  // Entry storage, loaded only with a legal write
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      active <= 1'b0;
      key    <= MAC_RST;
      msk    <= MAC_RST;
      vid    <= VID_RST;
      pri    <= PRI_RST;
    end else if (wr_en) begin
      active <= wr_active;
      key    <= wr_mac;
      msk    <= wr_mask;
      vid    <= wr_vid;
      pri    <= wr_pri;
    end
  end

  // Inactive entries never hit; mask zero bits are ignored
  assign hit = active && mvc_hit(src_mac, key, msk);
endmodule

/* File: hw/mvc_classifier.sv */
`timescale 1ns/1ps
// Function
// - Look up source address of untagged frames
// - Matched frame takes entry VLAN identifier
// - Valid VLAN frames continue ingress processing
// - Invalid VLAN frames are dropped
// - Mask f bits compare, 0 bits ignored
// - Entry VLAN identifier limited to 1..4094
// - Entry priority 0..7, larger is higher
// - Only active entries join the lookup
module mvc_classifier
  import mvc_pkg::*;
(
  input  wire logic                  sys_clk,
  input  wire logic                  rst_b,
  // Configuration write port
  input  wire logic                  cfg_wr,
  input  wire logic [IDX_W-1:0]      cfg_idx,
  input  wire logic                  cfg_active,
  input  wire logic [MAC_W-1:0]      cfg_mac,
  input  wire logic [MAC_W-1:0]      cfg_mask,
  input  wire logic [VID_W-1:0]      cfg_vid,
  input  wire logic [PRI_W-1:0]      cfg_pri,
  output logic                       cfg_reject,
  // VLAN table answer, combinational from outside
  output logic [VID_W-1:0]           vtab_vid,
  input  wire logic                  vtab_valid,
  // Frame request
  input  wire logic                  frm_valid,
  input  wire logic                  frm_untagged,
  input  wire logic [MAC_W-1:0]      frm_src_mac,
  // Verdict
  output logic                       res_valid,
  output logic                       res_match,
  output logic                       res_forward,
  output logic                       res_drop,
  output logic [VID_W-1:0]           res_vid,
  output logic [PRI_W-1:0]           res_pri
);
  import mvc_pkg::*;

  // All checks sample on the core clock and sleep while in reset
  default clocking cb_core @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);

  ////////////////////////////////////////////////////////////////////////
  // Entry array
  logic [NUM_ENTRIES-1:0] ent_hit;               // Per-entry hit
  logic [VID_W-1:0]       ent_vid [NUM_ENTRIES]; // Per-entry VLAN
  logic [PRI_W-1:0]       ent_pri [NUM_ENTRIES]; // Per-entry priority
  wire                    vid_ok;                // Write VLAN in range

  // Out-of-range VLAN identifiers reach storage only with a write that clears active
  assign vid_ok     = (cfg_vid >= VID_MIN) && (cfg_vid <= VID_MAX);
  assign cfg_reject = cfg_wr && cfg_active && !vid_ok;

  // One slot per entry; every slot compares the same source address,
  // so the search costs no extra cycle whatever the table size
  genvar g;
  generate
    for (g = 0; g < NUM_ENTRIES; g++) begin : g_ent
      wire we;  // Write to this slot; clearing active is always allowed
      assign we = cfg_wr && (cfg_idx == IDX_W'(g))
                  && (vid_ok || !cfg_active);
      mvc_entry u_ent (
        .sys_clk   (sys_clk),
        .rst_b     (rst_b),
        .wr_en     (we),
        .wr_active (cfg_active),
        .wr_mac    (cfg_mac),
        .wr_mask   (cfg_mask),
        .wr_vid    (cfg_vid),
        .wr_pri    (cfg_pri),
        .src_mac   (frm_src_mac),
        .hit       (ent_hit[g]),
        .vid       (ent_vid[g]),
        .pri       (ent_pri[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Selection: among several hits the highest priority wins,
  // ties go to the lowest index so the result is deterministic
  logic             sel_any;  // Some active entry hit
  logic [VID_W-1:0] sel_vid;  // Winning VLAN identifier
  logic [PRI_W-1:0] sel_pri;  // Winning priority

  always_comb begin
    sel_any = 1'b0;
    sel_vid = VID_RST;
    sel_pri = PRI_RST;
    // Strict greater-than keeps the lower index on a tie
    for (int i = 0; i < NUM_ENTRIES; i++) begin
      if (ent_hit[i] && (!sel_any || ent_pri[i] > sel_pri)) begin
        sel_any = 1'b1;
        sel_vid = ent_vid[i];
        sel_pri = ent_pri[i];
      end
    end
  end

  // Only untagged frames are searched
  wire lookup;
  assign lookup   = frm_valid && frm_untagged;
  assign vtab_vid = sel_vid;

  // The table answer is ignored when nothing hit
  mvc_verdict_t next_verdict;  // Verdict of this request
  assign next_verdict = !sel_any   ? MVC_NO_MATCH
                      : vtab_valid ? MVC_FORWARD
                      :              MVC_DROP;

  ////////////////////////////////////////////////////////////////////////
  // Registered verdict, one cycle after the request
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      // No verdict while reset is held
      res_valid   <= 1'b0;
      res_match   <= 1'b0;
      res_forward <= 1'b0;
      res_drop    <= 1'b0;
      res_vid     <= VID_RST;
      res_pri     <= PRI_RST;
    end else begin
      // Every edge: verdict of the request seen at this edge
      res_valid   <= lookup;
      res_match   <= lookup && sel_any;
      res_forward <= lookup && (next_verdict != MVC_DROP);
      res_drop    <= lookup && (next_verdict == MVC_DROP);
      res_vid     <= lookup && sel_any ? sel_vid : VID_RST;
      res_pri     <= lookup && sel_any ? sel_pri : PRI_RST;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  // Untagged request whose source address hit an active entry
  sequence s_req_hit;
    lookup && sel_any;
  endsequence

  // Untagged request that found no active entry
  sequence s_req_miss;
    lookup && !sel_any;
  endsequence

  // Table answer for the winning identifier
  sequence s_vlan_ok;
    vtab_valid;
  endsequence

  sequence s_vlan_bad;
    !vtab_valid;
  endsequence

  // Write that would activate an entry with an illegal identifier
  sequence s_cfg_bad;
    cfg_wr && cfg_active && (cfg_vid == VID_RST || cfg_vid > VID_MAX);
  endsequence

  // Write that retires an entry
  sequence s_retire;
    cfg_wr && !cfg_active;
  endsequence

  // Matched request: the table answer picks forward or drop
  a_drop_invalid: assert property ((s_req_hit and s_vlan_bad) |=>
    res_drop && !res_forward)
    else $error("invalid VLAN frame not dropped");
  a_fwd_valid: assert property ((s_req_hit and s_vlan_ok) |=>
    res_forward && !res_drop)
    else $error("valid VLAN frame not forwarded");

  // Matched request carries the winning identifier and priority
  a_vid_taken: assert property (s_req_hit |=>
    res_match && res_vid == $past(sel_vid))
    else $error("matched VLAN not assigned");
  a_pri_taken: assert property (s_req_hit |=>
    res_pri == $past(sel_pri))
    else $error("matched priority not assigned");

  // Unmatched request goes on untouched, with no identifier
  a_nomatch_pass: assert property (s_req_miss |=>
    res_forward && !res_match && !res_drop)
    else $error("unmatched frame not passed on");
  a_miss_zero: assert property (s_req_miss |=>
    res_vid == VID_RST && res_pri == PRI_RST)
    else $error("unmatched frame given an identifier");

  // Only untagged requests are looked up, and each one is answered
  a_tagged_skip: assert property (!lookup |=>
    !res_valid && !res_drop)
    else $error("verdict without untagged request");
  a_lookup_done: assert property (lookup |=> res_valid)
    else $error("untagged request not answered");

  // Identifier range is enforced at the write port
  a_vid_range: assert property (res_match |->
    res_vid >= VID_MIN && res_vid <= VID_MAX)
    else $error("VLAN out of range assigned");
  a_bad_reject: assert property (s_cfg_bad |-> cfg_reject)
    else $error("illegal VLAN write not rejected");
  a_good_accept: assert property (cfg_wr && cfg_vid >= VID_MIN
    && cfg_vid <= VID_MAX |-> !cfg_reject)
    else $error("legal VLAN write rejected");

  // A retired entry drops out of the lookup at the next edge
  a_retire_nohit: assert property (s_retire |=>
    !ent_hit[$past(cfg_idx)])
    else $error("hit on a retired entry");

  // No hitting entry may outrank the winner
  generate
    for (g = 0; g < NUM_ENTRIES; g++) begin : g_win
      a_pri_win: assert property (ent_hit[g] |->
        ent_pri[g] <= sel_pri)
        else $error("higher priority entry lost");
    end
  endgenerate
endmodule

/* File: testbench/mvc_vlan_table_model.sv */
`timescale 1ns/1ps
// VLAN table seen from the classifier; answers in the same cycle
module mvc_vlan_table_model #(
  // Identifiers at or above this are unknown to the table
  parameter logic [mvc_pkg::VID_W-1:0] FIRST_BAD = 12'h800
) (
  input  wire logic [mvc_pkg::VID_W-1:0] vtab_vid,
  output logic                           vtab_valid
);
  import mvc_pkg::*;
  // A range stands in for a real table; it keeps the model short
  assign vtab_valid = (vtab_vid < FIRST_BAD);
endmodule

/* File: testbench/test_mvc_classifier.sv */
`timescale 1ns/1ps
module test_mvc_classifier;
  import mvc_pkg::*;
  logic sys_clk = 1'b0, rst_b = 1'b0, cfg_wr = 1'b0, cfg_active = 1'b0;
  logic [IDX_W-1:0] cfg_idx = 3'h0;
  logic [MAC_W-1:0] cfg_mac = MAC_RST, cfg_mask = MAC_RST;
  logic [MAC_W-1:0] frm_src_mac = MAC_RST;
  logic [VID_W-1:0] cfg_vid = VID_RST, vtab_vid, res_vid;
  logic [PRI_W-1:0] cfg_pri = PRI_RST, res_pri;
  logic frm_valid = 1'b0, frm_untagged = 1'b0, vtab_valid, cfg_reject;
  logic res_valid, res_match, res_forward, res_drop;
  wire [3:0] res_flags = {res_valid, res_match, res_forward, res_drop};
  int   err_count = 0, num_checks = 0;
  localparam logic [MAC_W-1:0] ALL = 48'hFFFF_FFFF_FFFF;
  // 50 ns period
  always #25 sys_clk = ~sys_clk;
  mvc_classifier mvc_classifier_i (.sys_clk(sys_clk), .rst_b(rst_b),
    .cfg_wr(cfg_wr), .cfg_idx(cfg_idx), .cfg_active(cfg_active),
    .cfg_mac(cfg_mac), .cfg_mask(cfg_mask), .cfg_vid(cfg_vid),
    .cfg_pri(cfg_pri), .cfg_reject(cfg_reject), .vtab_vid(vtab_vid),
    .vtab_valid(vtab_valid), .frm_valid(frm_valid),
    .frm_untagged(frm_untagged), .frm_src_mac(frm_src_mac),
    .res_valid(res_valid), .res_match(res_match),
    .res_forward(res_forward), .res_drop(res_drop), .res_vid(res_vid),
    .res_pri(res_pri));
  mvc_vlan_table_model mvc_vlan_table_model_i (.vtab_vid(vtab_vid),
    .vtab_valid(vtab_valid));
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop;
    if (err_count == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // One entry write; reject flag is combinational, so look before the edge
  task automatic cfg(input logic [2:0] i, input logic a,
    input logic [47:0] m, k, input logic [11:0] v, input logic [2:0] p,
    input logic rej);
    @(negedge sys_clk);
    {cfg_wr, cfg_idx, cfg_active, cfg_mac, cfg_mask} = {1'b1, i, a, m, k};
    {cfg_vid, cfg_pri} = {v, p};
    #1 chk(16'(cfg_reject), 16'(rej));
    @(negedge sys_clk);
    cfg_wr = 1'b0;
  endtask
  // One request; flags are valid, match, forward, drop one cycle later
  task automatic frm(input logic [47:0] m, input logic u,
    input logic [3:0] f, input logic [11:0] v, input logic [2:0] p);
    @(negedge sys_clk);
    {frm_valid, frm_untagged, frm_src_mac} = {1'b1, u, m};
    #1;
    if (u) chk(16'(vtab_vid), 16'(v));
    @(negedge sys_clk);
    frm_valid = 1'b0;
    chk(16'({res_valid, res_match, res_forward, res_drop}), 16'(f));
    chk(16'(res_vid), 16'(v));
    chk(16'(res_pri), 16'(p));
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Empty table: the frame passes with no identifier
  task automatic sc_empty;
    frm(48'h0013_4912_3456, 1'b1, 4'b1010, 12'h000, 3'h0);
  endtask
  // Lower half of the address is ignored by the mask
  task automatic sc_mask;
    cfg(3'h0, 1'b1, 48'h0013_4900_0000, 48'hFFFF_FF00_0000, 12'h005, 3'h3,
      1'b0);
    frm(48'h0013_4912_3456, 1'b1, 4'b1110, 12'h005, 3'h3);
    frm(48'h0013_4A12_3456, 1'b1, 4'b1010, 12'h000, 3'h0);
  endtask
  // Two hits: higher priority wins, its identifier is unknown to the table
  task automatic sc_prio_drop;
    cfg(3'h1, 1'b1, 48'h0013_49AA_BBCC, ALL, 12'h900, 3'h7, 1'b0);
    frm(48'h0013_49AA_BBCC, 1'b1, 4'b1101, 12'h900, 3'h7);
  endtask
  // Identifier limits at both ends
  task automatic sc_range;
    cfg(3'h2, 1'b1, 48'h0000_0000_0077, ALL, 12'h000, 3'h1, 1'b1);
    cfg(3'h2, 1'b1, 48'h0000_0000_0077, ALL, 12'hFFF, 3'h1, 1'b1);
    frm(48'h0000_0000_0077, 1'b1, 4'b1010, 12'h000, 3'h0);
    cfg(3'h2, 1'b1, 48'h0000_0000_0077, ALL, 12'h001, 3'h1, 1'b0);
    frm(48'h0000_0000_0077, 1'b1, 4'b1110, 12'h001, 3'h1);
    cfg(3'h2, 1'b1, 48'h0000_0000_0077, ALL, 12'hFFE, 3'h1, 1'b0);
    frm(48'h0000_0000_0077, 1'b1, 4'b1101, 12'hFFE, 3'h1);
  endtask
  // Retiring entry 1 hands the address back to entry 0
  task automatic sc_inactive;
    cfg(3'h1, 1'b0, 48'h0013_49AA_BBCC, ALL, 12'h000, 3'h7, 1'b0);
    frm(48'h0013_49AA_BBCC, 1'b1, 4'b1110, 12'h005, 3'h3);
  endtask
  // Requests on consecutive cycles each get their own verdict
  task automatic sc_burst;
    @(negedge sys_clk);
    {frm_valid, frm_untagged} = 2'b11;
    frm_src_mac = 48'h0013_4912_3456;
    @(negedge sys_clk);
    frm_src_mac = 48'h0000_0000_0077;
    chk(16'(res_flags), 16'h000E);
    chk(16'(res_vid), 16'h0005);
    chk(16'(res_pri), 16'h0003);
    @(negedge sys_clk);
    frm_valid = 1'b0;
    chk(16'(res_flags), 16'h000D);
    chk(16'(res_vid), 16'h0FFE);
    chk(16'(res_pri), 16'h0001);
  endtask
  // Tagged frames are not looked up
  task automatic sc_tagged;
    frm(48'h0013_4912_3456, 1'b0, 4'b0000, 12'h000, 3'h0);
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Hang guard
  initial begin
    #200us;
    err_count++;
    report_and_stop();
  end
  initial begin
    repeat (3) @(negedge sys_clk);
    chk(16'(res_valid), 16'h0000);
    rst_b = 1'b1;
    sc_empty();
    sc_mask();
    sc_prio_drop();
    sc_range();
    sc_inactive();
    sc_burst();
    sc_tagged();
    report_and_stop();
  end
endmodule
